// *** mdsw_cfg.svh ***
`ifndef MDSW_CFG_SVH
`define MDSW_CFG_SVH

`define MDSW_FN_DIAG 8'h08
`define MDSW_FN_WRMULTI 8'h10
`define MDSW_SUB_ECHO 16'h0000
`define MDSW_BCAST_ADDR 8'h00
`define MDSW_MAX_REGS 16'h007d
`define MDSW_BC_MIN 8'h02
`define MDSW_BC_MAX 8'hfa
`define MDSW_CRC_INIT 16'hffff
`define MDSW_CRC_POLY 16'ha001
`define MDSW_CRC_RESIDUE 16'h0000
`define MDSW_DIAG_LEN 9'h008
`define MDSW_WR_OVERHEAD 9'h009
`define MDSW_HDR_BYTES 7
`define MDSW_DATA_POS 9'h007
`define MDSW_BC_POS 3'h6
`define MDSW_RSP_CRC_LO 3'h6
`define MDSW_RSP_CRC_HI 3'h7
`define MDSW_LEN_MAX 9'h1ff

`endif

// *** mdsw_pkg.sv ***
package mdsw_pkg;

    typedef enum logic [1:0] {
        ST_RX,
        ST_WRITE,
        ST_RESP
    } mdsw_state_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] data;
    } mdsw_wr_t;

endpackage

// *** mdsw_fifo.sv ***
`timescale 1ns/1ps
module mdsw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // Depth must be a power of two; the extra pointer bit tells full
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    wire logic [AW:0] fill = wr_ptr_reg - rd_ptr_reg;
    wire logic push = in_valid && in_ready;
    wire logic pop = out_valid && out_ready;

    assign in_ready = (fill != DEPTH[AW:0]);
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else if (clr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + {{AW{1'b0}}, push};
            rd_ptr_reg <= rd_ptr_reg + {{AW{1'b0}}, pop};
        end
    end
endmodule

// *** mdsw_top.sv ***
// Contract
// - Echo query needs a nonzero address; zero is never broadcast.
// - Echo query: function 08, subfunction 0000, any two-byte data value.
// - Valid echo query is answered with an identical frame, CRC included.
// - Broadcast queries are carried out but never answered.
// - Multiple write accepts address zero as broadcast, writes without reply.
// - Start field is register number minus 40001; field goes out unchanged.
// - Register count of a multiple write is at most 125.
// - Byte count equals twice register count, within 02 to fa.
// - Data words high byte first, from start register upward.
// - Write frame: address, function, start, count, byte count, data, CRC.
// - Write reply copies address, function, start, count, adds fresh CRC.
`timescale 1ns/1ps
`include "mdsw_cfg.svh"
module mdsw_top
    import mdsw_pkg::*;
#(
    parameter int STAGE_DEPTH = 128,
    parameter int TX_DEPTH = 8
) (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Own station address
    input wire logic [7:0] MY_ADDR,
    // Received bytes from the character framer
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    input wire logic RX_END,
    // Response bytes toward the transmitter
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    input wire logic TX_READY,
    // Holding register write port
    output logic WR_EN,
    output mdsw_wr_t WR_CMD,
    // Status
    output logic BUSY
);
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MDSW_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    mdsw_state_t state_reg;
    mdsw_state_t state_next;
    logic [8:0] len_reg;
    logic [7:0] hdr_reg [0:`MDSW_HDR_BYTES-1];
    logic [15:0] crc_reg;
    logic [7:0] hi_reg;
    logic [6:0] wofs_reg;
    logic [2:0] ridx_reg;
    logic bcast_reg;
    logic tx_valid_reg;
    logic [7:0] tx_data_reg;
    logic wr_en_reg;
    mdsw_wr_t wr_cmd_reg;
    logic busy_reg;

    // Header fields
    wire logic [7:0] f_addr = hdr_reg[0];
    wire logic [7:0] f_func = hdr_reg[1];
    wire logic [15:0] f_w2 = {hdr_reg[2], hdr_reg[3]};
    wire logic [15:0] f_w4 = {hdr_reg[4], hdr_reg[5]};
    wire logic [7:0] f_bc = hdr_reg[6];

    wire logic in_rx = (state_reg == ST_RX);
    wire logic rx_take = in_rx && RX_VALID;
    wire logic rx_close = in_rx && RX_END;

    // Address zero is broadcast only for the multiple write
    wire logic is_bcast = (f_addr == `MDSW_BCAST_ADDR);
    wire logic own_addr = (f_addr == MY_ADDR) && !is_bcast;
    wire logic crc_ok = (crc_reg == `MDSW_CRC_RESIDUE);

    wire logic is_diag = (f_func == `MDSW_FN_DIAG) && own_addr
        && (f_w2 == `MDSW_SUB_ECHO) && (len_reg == `MDSW_DIAG_LEN);

    // Count and byte-count limits, known before the first data byte
    wire logic lim_ok = (f_w4 != 16'h0000) && (f_w4 <= `MDSW_MAX_REGS)
        && (f_bc >= `MDSW_BC_MIN) && (f_bc <= `MDSW_BC_MAX)
        && ({f_w4[14:0], 1'b0} == {8'h00, f_bc});
    wire logic is_wr_hdr = (f_func == `MDSW_FN_WRMULTI)
        && (own_addr || is_bcast) && lim_ok;
    wire logic is_wr = is_wr_hdr
        && (len_reg == `MDSW_WR_OVERHEAD + {1'b0, f_bc});

    wire logic accept = rx_close && crc_ok && (is_diag || is_wr);

    // Data bytes sit between the byte count and the two CRC bytes
    wire logic [8:0] data_pos = len_reg - `MDSW_DATA_POS;
    wire logic in_data = is_wr_hdr && (len_reg >= `MDSW_DATA_POS)
        && (data_pos < {1'b0, f_bc});
    wire logic stage_push = rx_take && in_data && data_pos[0];
    wire logic [15:0] stage_word = {hi_reg, RX_DATA};

    // Staged words are held back until the CRC proves the frame good
    wire logic stage_clr = rx_close && !(accept && is_wr);
    wire logic stage_valid;
    wire logic [15:0] stage_data;
    wire logic stage_pop = (state_reg == ST_WRITE) && stage_valid;

    mdsw_fifo #(
        .WIDTH(16),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .clr(stage_clr),
        .in_valid(stage_push),
        .in_ready(),
        .in_data(stage_word),
        .out_valid(stage_valid),
        .out_ready(stage_pop),
        .out_data(stage_data)
    );

    // Reply bytes: six header bytes then the recomputed CRC
    wire logic [7:0] rsp_byte = (ridx_reg == `MDSW_RSP_CRC_LO) ? crc_reg[7:0]
        : (ridx_reg == `MDSW_RSP_CRC_HI) ? crc_reg[15:8]
        : hdr_reg[ridx_reg];
    wire logic txq_ready;
    wire logic txq_valid;
    wire logic [7:0] txq_data;
    wire logic rsp_push = (state_reg == ST_RESP) && txq_ready;
    wire logic rsp_last = rsp_push && (ridx_reg == `MDSW_RSP_CRC_HI);
    wire logic tx_load = txq_valid && (!tx_valid_reg || TX_READY);

    // The queue fills while the transmitter stalls, pausing the reply
    mdsw_fifo #(
        .WIDTH(8),
        .DEPTH(TX_DEPTH)
    ) u_txq (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .clr(1'b0),
        .in_valid(rsp_push),
        .in_ready(txq_ready),
        .in_data(rsp_byte),
        .out_valid(txq_valid),
        .out_ready(tx_load),
        .out_data(txq_data)
    );

    wire logic [7:0] crc_byte = rx_take ? RX_DATA : rsp_byte;
    wire logic crc_adv = rx_take || (rsp_push && ridx_reg < `MDSW_RSP_CRC_LO);
    // Restart after the reply too, else the next frame starts from its CRC
    wire logic [15:0] crc_next = rx_close || rsp_last
        ? `MDSW_CRC_INIT
        : crc_adv ? crc_step(crc_reg, crc_byte) : crc_reg;
    wire logic [8:0] len_next = rx_close ? 9'h000
        : (rx_take && len_reg != `MDSW_LEN_MAX) ? len_reg + 9'h001 : len_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RX: begin
                if (accept) begin
                    state_next = is_diag ? ST_RESP : ST_WRITE;
                end
            end
            ST_WRITE: begin
                if (!stage_valid) begin
                    state_next = bcast_reg ? ST_RX : ST_RESP;
                end
            end
            ST_RESP: begin
                if (rsp_last) begin
                    state_next = ST_RX;
                end
            end
            default: state_next = ST_RX;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < `MDSW_HDR_BYTES; g++) begin : g_hdr
            always_ff @(posedge SYS_CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    hdr_reg[g] <= 8'h00;
                end else if (rx_take && len_reg == 9'(g)) begin
                    hdr_reg[g] <= RX_DATA;
                end
            end
        end
    endgenerate

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= ST_RX;
            len_reg <= 9'h000;
            crc_reg <= `MDSW_CRC_INIT;
            hi_reg <= 8'h00;
            bcast_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            len_reg <= len_next;
            crc_reg <= crc_next;
            hi_reg <= rx_take ? RX_DATA : hi_reg;
            bcast_reg <= accept ? is_bcast : bcast_reg;
            busy_reg <= (state_next != ST_RX);
        end
    end

    // Register writes run only after the whole frame checked out
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wofs_reg <= 7'h00;
            wr_en_reg <= 1'b0;
            wr_cmd_reg <= '0;
        end else begin
            wofs_reg <= accept ? 7'h00 : wofs_reg + {6'h00, stage_pop};
            wr_en_reg <= stage_pop;
            if (stage_pop) begin
                wr_cmd_reg.addr <= f_w2 + {9'h000, wofs_reg};
                wr_cmd_reg.data <= stage_data;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ridx_reg <= 3'h0;
            tx_valid_reg <= 1'b0;
            tx_data_reg <= 8'h00;
        end else begin
            ridx_reg <= accept ? 3'h0 : ridx_reg + {2'h0, rsp_push};
            if (tx_load) begin
                tx_valid_reg <= 1'b1;
                tx_data_reg <= txq_data;
            end else if (TX_READY) begin
                tx_valid_reg <= 1'b0;
            end
        end
    end

    assign TX_VALID = tx_valid_reg;
    assign TX_DATA = tx_data_reg;
    assign WR_EN = wr_en_reg;
    assign WR_CMD = wr_cmd_reg;
    assign BUSY = busy_reg;
endmodule

// *** mdsw_properties.sv ***
`timescale 1ns/1ps
module mdsw_properties
    import mdsw_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    // Watched ports
    input wire logic RX_END,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_READY,
    input wire logic WR_EN,
    input wire mdsw_wr_t WR_CMD,
    input wire logic BUSY
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);
    chk_tx_hold: assert property (
        TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("reply byte changed before taken");
    chk_wr_ascend: assert property (
        WR_EN && $past(WR_EN) |->
        WR_CMD.addr == $past(WR_CMD.addr) + 16'h0001)
        else $error("write address not ascending");
    chk_wr_first: assert property (
        WR_EN && !$past(WR_EN) |-> $past(RX_END, 2))
        else $error("first write not two cycles after frame end");
    chk_busy_cause: assert property (
        $rose(BUSY) |-> $past(RX_END))
        else $error("busy without a closed frame");
    chk_busy_bound: assert property (
        $rose(BUSY) |-> ##[1:400] !BUSY)
        else $error("busy never ends");
    chk_wr_busy: assert property (
        WR_EN |-> BUSY)
        else $error("write outside busy");
    chk_wr_no_tx: assert property (
        WR_EN |-> !TX_VALID)
        else $error("reply during writes");
    chk_tx_quiet: assert property (
        !BUSY && !TX_VALID |=> !TX_VALID)
        else $error("reply without a frame");
    cover property (WR_EN ##1 WR_EN);
    cover property (TX_VALID && !TX_READY);
    cover property ($fell(BUSY) && !TX_VALID);
endmodule
bind mdsw_top mdsw_properties mdsw_properties_i (.SYS_CLK(SYS_CLK),
    .RESET_N(RESET_N), .RX_END(RX_END), .TX_VALID(TX_VALID),
    .TX_DATA(TX_DATA), .TX_READY(TX_READY), .WR_EN(WR_EN),
    .WR_CMD(WR_CMD), .BUSY(BUSY));

// *** mdsw_master_model.sv ***
`timescale 1ns/1ps
module mdsw_master_model (
    // Clock
    input wire logic clk,
    // Query bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_end,
    // Reply bytes
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [7:0] fq[$];
    logic [7:0] rq[$];
    logic stall = 1'b0;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        rx_end = 1'b0;
    end
    assign tx_ready = !stall;
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            rq.push_back(tx_data);
        end
    end
    // Reflected CRC-16 over the first n queued bytes
    function automatic logic [15:0] crc(input int n);
        logic [15:0] c;
        c = 16'hffff;
        for (int i = 0; i < n; i++) begin
            c = c ^ {8'h00, fq[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
            end
        end
        return c;
    endfunction
    // Bytes one a cycle, CRC low then high, then the end mark
    task automatic send(input logic bad);
        logic [15:0] c;
        c = crc(fq.size()) ^ {15'h0000, bad};
        fq.push_back(c[7:0]);
        fq.push_back(c[15:8]);
        rq.delete();
        foreach (fq[i]) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= fq[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        // Idle line never repeats the last byte
        rx_data <= ~rx_data;
        rx_end <= 1'b1;
        @(posedge clk);
        rx_end <= 1'b0;
    endtask
endmodule

// *** tb_mdsw_top.sv ***
`timescale 1ns/1ps
module tb_mdsw_top;
    import mdsw_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] my_addr = 8'h19;
    logic rx_valid, rx_end, tx_valid, tx_ready, wr_en, busy;
    logic [7:0] rx_data, tx_data;
    mdsw_wr_t wr_cmd;
    mdsw_wr_t wq[$];
    int n_fail = 0;
    int tests_run = 0;
    always #12.5 sys_clk = ~sys_clk;
    mdsw_top mdsw_top_i (.SYS_CLK(sys_clk), .RESET_N(reset_n),
        .MY_ADDR(my_addr), .RX_VALID(rx_valid), .RX_DATA(rx_data),
        .RX_END(rx_end), .TX_VALID(tx_valid), .TX_DATA(tx_data),
        .TX_READY(tx_ready), .WR_EN(wr_en), .WR_CMD(wr_cmd), .BUSY(busy));
    mdsw_master_model m (.clk(sys_clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_end(rx_end), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    always @(posedge sys_clk) begin
        if (wr_en === 1'b1) begin
            wq.push_back(wr_cmd);
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("fails %0d checks %0d", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Next query only once the block is idle again
    task automatic xfer(input logic bad, input int stl);
        logic done;
        done = 1'b0;
        wq.delete();
        m.stall <= stl > 0;
        m.send(bad);
        for (int i = 0; i < 600; i++) begin
            @(posedge sys_clk);
            if (i == stl) begin
                m.stall <= 1'b0;
            end
            if (i > 20 && busy === 1'b0 && tx_valid === 1'b0) begin
                done = 1'b1;
                break;
            end
        end
        if (!done) begin
            n_fail++;
            $display("CHECK FAILED t=%0t block never went idle", $time);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] n,
        input logic [7:0] bc);
        m.fq = '{a, 8'h10, 8'h03, 8'hee, n[15:8], n[7:0], bc};
        for (int i = 1; i <= n; i++) begin
            m.fq.push_back(8'h00);
            m.fq.push_back(8'(5 * i));
        end
    endtask
    task automatic t_echo();
        for (int d = 0; d < 2; d++) begin
            m.fq = '{my_addr, 8'h08, 8'h00, 8'h00, {8{d[0]}}, {8{d[0]}}};
            xfer(1'b0, 0);
            check(m.rq.size(), 8);
            for (int i = 0; i < 8; i++) begin
                check(m.rq[i], m.fq[i]);
            end
            check(wq.size(), 0);
        end
    endtask
    task automatic t_refuse();
        for (int k = 0; k < 4; k++) begin
            m.fq = '{k == 0 ? 8'h00 : k == 2 ? 8'h18 : my_addr, 8'h08,
                8'h00, k == 1 ? 8'h01 : 8'h00, 8'h12, 8'h34};
            xfer(k == 3, 0);
            check(m.rq.size(), 0);
            check(wq.size(), 0);
        end
    endtask
    task automatic t_write();
        wr(my_addr, 16'h0002, 8'h04);
        xfer(1'b0, 30);
        check(wq.size(), 2);
        for (int i = 0; i < 2; i++) begin
            check(wq[i], {16'h03ee + 16'(i), 16'(5 * i + 5)});
        end
        check(m.rq.size(), 8);
        for (int i = 0; i < 6; i++) begin
            check(m.rq[i], m.fq[i]);
        end
        check({m.rq[6], m.rq[7]}, 16'h2261);
    endtask
    task automatic t_bcast();
        wr(8'h00, 16'h0001, 8'h02);
        xfer(1'b0, 0);
        check(wq.size(), 1);
        check(m.rq.size(), 0);
    endtask
    task automatic t_limits();
        logic [15:0] nt[4] = '{16'h007d, 16'h007e, 16'h0002, 16'h0000};
        logic [7:0] bt[4] = '{8'hfa, 8'hfc, 8'h05, 8'h00};
        for (int k = 0; k < 4; k++) begin
            wr(my_addr, nt[k], bt[k]);
            xfer(1'b0, 0);
            check(wq.size(), k == 0 ? 125 : 0);
            check(m.rq.size(), k == 0 ? 8 : 0);
        end
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_echo();
        t_refuse();
        t_write();
        t_bcast();
        t_limits();
        print_verdict();
    end
    initial begin
        #1000000;
        n_fail++;
        print_verdict();
    end
endmodule
